// ===== core/lac_hash.sv
// Address hash engine for member selection
`timescale 1ns/1ns
`default_nettype none
module lac_hash (
  lac_hash_if.engine hif
);

  function automatic logic [7:0] fold48(input logic [47:0] v);
    fold48 = v[7:0] ^ v[15:8] ^ v[23:16] ^ v[31:24] ^ v[39:32] ^ v[47:40];
  endfunction

  function automatic logic [7:0] fold32(input logic [31:0] v);
    fold32 = v[7:0] ^ v[15:8] ^ v[23:16] ^ v[31:24];
  endfunction

  // Pure function of inputs, so equal addresses always hash alike
  always_comb begin
    unique case (hif.sel)
      lac_pkg::HASH_SOURCE_MAC:      hif.hash = fold48(hif.src_mac);
      lac_pkg::HASH_DESTINATION_MAC: hif.hash = fold48(hif.dst_mac);
      lac_pkg::HASH_SOURCE_IP:       hif.hash = fold32(hif.hash_source_ip);
      lac_pkg::HASH_DESTINATION_IP:  hif.hash = fold32(hif.hash_destination_ip);
      lac_pkg::HASH_BOTH_IP:         hif.hash = fold32(hif.hash_source_ip ^ hif.hash_destination_ip);
      default:                       hif.hash = fold48(hif.src_mac ^ hif.dst_mac);
    endcase
  end

endmodule
`default_nettype wire

// ===== core/lac_hash_if.sv
// Hash request and result between controller and hash engine
`timescale 1ns/1ns
`default_nettype none
interface lac_hash_if;
  lac_pkg::lac_hash_t sel;
  logic [47:0]        src_mac;
  logic [47:0]        dst_mac;
  logic [31:0]        hash_source_ip;
  logic [31:0]        hash_destination_ip;
  logic [7:0]         hash;
  modport client (output sel, output src_mac, output dst_mac, output hash_source_ip, output hash_destination_ip, input hash);
  modport engine (input sel, input src_mac, input dst_mac, input hash_source_ip, input hash_destination_ip, output hash);
endinterface
`default_nettype wire

// ===== core/lac_pkg.sv
// Shared constants and types for the link aggregation controller
package lac_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PORTS   = 28;
  localparam int unsigned NUM_GROUPS  = 8;
  localparam int unsigned MAX_MEMBERS = 8;
  localparam int unsigned PORT_W      = 5;
  localparam int unsigned GROUP_W     = 4;
  localparam int unsigned PRIO_W      = 16;
  localparam int unsigned SIL_W       = 7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned TICK_S           = 1;
  localparam int unsigned SECOND_CYCLES    = CLK_HZ * TICK_S;
  localparam int unsigned LONG_INTERVAL_S  = 30;
  localparam int unsigned SHORT_INTERVAL_S = 1;
  localparam int unsigned MISS_LIMIT       = 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] IRQ_STATUS_OFF  = 12'h000;
  localparam logic [11:0] IRQ_MASK_OFF    = 12'h004;
  localparam logic [11:0] PORT_ACTIVE_OFF = 12'h008;
  localparam logic [11:0] SILENCE_OFF     = 12'h00C;
  localparam logic [11:0] LINK_STAT_OFF   = 12'h010;
  localparam logic [11:0] AGG_STAT_OFF    = 12'h014;
  localparam logic [11:0] INDIV_STAT_OFF  = 12'h018;
  localparam logic [11:0] DOWN_STAT_OFF   = 12'h01C;
  localparam logic [11:0] GROUP_CFG_OFF   = 12'h020;
  localparam logic [11:0] PORT_CFG_OFF    = 12'h040;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned GCFG_MODE_BIT  = 0;
  localparam int unsigned GCFG_HASH_LSB  = 1;
  localparam int unsigned PCFG_GROUP_LSB = 0;
  localparam int unsigned PCFG_PRIO_LSB  = 16;
  localparam int unsigned IRQ_REFUSED    = 0;
  localparam int unsigned IRQ_REMOVED    = 1;
  localparam int unsigned IRQ_JOINED     = 2;
  localparam int unsigned IRQ_W          = 3;
  localparam logic [PRIO_W-1:0]    PRIO_RESET   = 16'h8000;
  localparam logic [NUM_PORTS-1:0] ACTIVE_RESET = 28'hFFFFFFF;

  typedef enum logic [2:0] {
    HASH_SOURCE_MAC, HASH_DESTINATION_MAC, HASH_BOTH_MAC,
    HASH_SOURCE_IP, HASH_DESTINATION_IP, HASH_BOTH_IP
  } lac_hash_t;

endpackage

// ===== core/lac_tick.sv
// One-second tick and thirty-second phase for protocol timing
`timescale 1ns/1ns
`default_nettype none
module lac_tick #(
  parameter int unsigned TICK_CYCLES = lac_pkg::SECOND_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  output logic            tick,
  output logic [4:0]      phase
);

  logic [23:0] div_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 24'h000000;
    end else if (div_r == 24'(TICK_CYCLES - 1)) begin
      div_r <= 24'h000000;
    end else begin
      div_r <= div_r + 24'h000001;
    end
  end

  assign tick = (div_r == 24'(TICK_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 5'h00;
    end else if (tick) begin
      phase <= (phase == 5'(lac_pkg::LONG_INTERVAL_S - 1)) ? 5'h00 : phase + 5'h01;
    end
  end

endmodule
`default_nettype wire

// ===== core/lac_top.sv
// Link aggregation controller: trunk membership, LACP timing, frame distribution
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Up to eight trunk groups operate independently at once.
// - A group never holds more than eight member ports.
// - Each port has a group index, none or one to eight; equal index means same trunk.
// - Each group runs either static or LACP membership, one mode only.
// - Assigning an inactive port to a group is refused.
// - Per group, hashing on source MAC, destination MAC or both.
// - Per group, hashing on source IP, destination IP or both.
// - Hash selection may change while the group is live.
// - Per-port priority resets to 32768; bigger number means lower priority.
// - Long mode, the default, sends a protocol unit every 30 seconds.
// - Short mode sends every second, catching failure in about three seconds.
// - Three missed expected protocol units end the port's aggregation; its group index is kept.
// - A port whose negotiation succeeded is reported aggregated.
// - An up LACP port without matching partner is reported individual.
// - An LACP port without link is reported link-down.
module lac_top #(
  parameter int unsigned TICK_CYCLES = lac_pkg::SECOND_CYCLES
) (
  input  wire logic                            sys_clk,
  input  wire logic                            reset_n,
  input  wire logic [11:0]                     paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     pwdata,
  output logic [31:0]                          prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [lac_pkg::NUM_PORTS-1:0]   link_up,
  input  wire logic [lac_pkg::NUM_PORTS-1:0]   lacpdu_rx,
  input  wire logic [lac_pkg::NUM_PORTS-1:0]   partner_match,
  output logic [lac_pkg::NUM_PORTS-1:0]        lacpdu_tx,
  output logic [lac_pkg::NUM_PORTS-1:0]        port_aggregated,
  input  wire logic                            frame_valid,
  input  wire logic [lac_pkg::GROUP_W-1:0]     frame_group,
  input  wire logic [47:0]                     src_mac,
  input  wire logic [47:0]                     dst_mac,
  input  wire logic [31:0]                     hash_source_ip,
  input  wire logic [31:0]                     hash_destination_ip,
  output logic                                 dist_valid,
  output logic                                 dist_none,
  output logic [lac_pkg::PORT_W-1:0]           dist_port,
  output logic [lac_pkg::PORT_W-1:0]           dist_lead_port,
  output logic                                 irq
);

  localparam int unsigned NP = lac_pkg::NUM_PORTS;
  localparam int unsigned NG = lac_pkg::NUM_GROUPS;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NG-1:0]                  grp_lacp_r;
  lac_pkg::lac_hash_t             grp_hash_r [NG];
  logic [lac_pkg::GROUP_W-1:0]    port_grp_r [NP];
  logic [lac_pkg::PRIO_W-1:0]     port_prio_r [NP];
  logic [lac_pkg::SIL_W-1:0]      silence_r [NP];
  logic [NP-1:0]                  port_active_r;
  logic [NP-1:0]                  short_mode_r;
  logic [NP-1:0]                  seen_r;
  logic [NP-1:0]                  agg_nxt;
  logic [NP-1:0]                  indiv_nxt;
  logic [NP-1:0]                  down_nxt;
  logic [NP-1:0]                  expire;
  logic [NP-1:0]                  port_lacp;
  logic [lac_pkg::IRQ_W-1:0]      irq_stat_r;
  logic [lac_pkg::IRQ_W-1:0]      irq_mask_r;
  logic [lac_pkg::IRQ_W-1:0]      irq_event;
  logic                           refused;
  logic                           tick;
  logic [4:0]                     phase;
  logic                           wr_en;
  logic                           rd_setup;
  logic [31:0]                    rdata_nxt;
  logic                           err_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [lac_pkg::SIL_W-1:0] silence_limit(input logic short_mode);
    silence_limit = short_mode ? lac_pkg::SIL_W'(lac_pkg::MISS_LIMIT * lac_pkg::SHORT_INTERVAL_S)
                               : lac_pkg::SIL_W'(lac_pkg::MISS_LIMIT * lac_pkg::LONG_INTERVAL_S);
  endfunction

  // Members of a group other than the port being reassigned
  function automatic logic [4:0] others_in(input logic [lac_pkg::GROUP_W-1:0] g,
                                           input int unsigned skip);
    others_in = 5'h00;
    for (int unsigned q = 0; q < NP; q++) begin
      if (q != skip && port_grp_r[q] == g) begin
        others_in = others_in + 5'h01;
      end
    end
  endfunction

  function automatic logic hit(input logic [11:0] base, input int unsigned n, output int unsigned idx);
    idx = (32'(paddr) - 32'(base)) >> 2;
    hit = (paddr >= base) && (paddr[1:0] == 2'b00) && (idx < n);
  endfunction

  // ----------------------------------------------------------------
  // Timing base
  // ----------------------------------------------------------------
  lac_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .tick    (tick),
    .phase   (phase)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Data is fetched in setup so prdata comes from a flop at zero wait
  assign pready   = psel & penable;
  assign wr_en    = psel & penable & pwrite & ~pslverr;
  assign rd_setup = psel & ~penable;

  always_comb begin
    int unsigned i;
    i         = 0;
    rdata_nxt = 32'h00000000;
    err_nxt   = 1'b0;
    if (paddr == lac_pkg::IRQ_STATUS_OFF) begin
      rdata_nxt[lac_pkg::IRQ_W-1:0] = irq_stat_r;
    end else if (paddr == lac_pkg::IRQ_MASK_OFF) begin
      rdata_nxt[lac_pkg::IRQ_W-1:0] = irq_mask_r;
    end else if (paddr == lac_pkg::PORT_ACTIVE_OFF) begin
      rdata_nxt[NP-1:0] = port_active_r;
    end else if (paddr == lac_pkg::SILENCE_OFF) begin
      rdata_nxt[NP-1:0] = short_mode_r;
    end else if (paddr == lac_pkg::LINK_STAT_OFF) begin
      rdata_nxt[NP-1:0] = link_up;
    end else if (paddr == lac_pkg::AGG_STAT_OFF) begin
      rdata_nxt[NP-1:0] = port_aggregated;
    end else if (paddr == lac_pkg::INDIV_STAT_OFF) begin
      rdata_nxt[NP-1:0] = indiv_nxt;
    end else if (paddr == lac_pkg::DOWN_STAT_OFF) begin
      rdata_nxt[NP-1:0] = down_nxt;
    end else if (hit(lac_pkg::GROUP_CFG_OFF, NG, i)) begin
      rdata_nxt[lac_pkg::GCFG_MODE_BIT]                           = grp_lacp_r[i];
      rdata_nxt[lac_pkg::GCFG_HASH_LSB +: 3]                      = grp_hash_r[i];
    end else if (hit(lac_pkg::PORT_CFG_OFF, NP, i)) begin
      rdata_nxt[lac_pkg::PCFG_GROUP_LSB +: lac_pkg::GROUP_W]      = port_grp_r[i];
      rdata_nxt[lac_pkg::PCFG_PRIO_LSB +: lac_pkg::PRIO_W]        = port_prio_r[i];
    end else begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata  <= pwrite ? 32'h00000000 : rdata_nxt;
      pslverr <= err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Global registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_active_r <= lac_pkg::ACTIVE_RESET;
      short_mode_r  <= '0;
      irq_mask_r    <= '0;
    end else if (wr_en) begin
      if (paddr == lac_pkg::PORT_ACTIVE_OFF) begin
        port_active_r <= pwdata[NP-1:0];
      end
      if (paddr == lac_pkg::SILENCE_OFF) begin
        short_mode_r <= pwdata[NP-1:0];
      end
      if (paddr == lac_pkg::IRQ_MASK_OFF) begin
        irq_mask_r <= pwdata[lac_pkg::IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Group configuration
  // ----------------------------------------------------------------
  // One mode bit per group keeps static and LACP from mixing
  always_ff @(posedge sys_clk or negedge reset_n) begin
    int unsigned i;
    if (!reset_n) begin
      grp_lacp_r <= '0;
      for (int g = 0; g < NG; g++) begin
        grp_hash_r[g] <= lac_pkg::HASH_BOTH_MAC;
      end
    end else if (wr_en && hit(lac_pkg::GROUP_CFG_OFF, NG, i)) begin
      grp_lacp_r[i] <= pwdata[lac_pkg::GCFG_MODE_BIT];
      grp_hash_r[i] <= lac_pkg::lac_hash_t'(pwdata[lac_pkg::GCFG_HASH_LSB +: 3]);
    end
  end

  // ----------------------------------------------------------------
  // Port configuration
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    int unsigned i;
    logic [lac_pkg::GROUP_W-1:0] g;
    if (!reset_n) begin
      refused <= 1'b0;
      for (int p = 0; p < NP; p++) begin
        port_grp_r[p]  <= '0;
        port_prio_r[p] <= lac_pkg::PRIO_RESET;
      end
    end else begin
      refused <= 1'b0;
      if (wr_en && hit(lac_pkg::PORT_CFG_OFF, NP, i)) begin
        g = pwdata[lac_pkg::PCFG_GROUP_LSB +: lac_pkg::GROUP_W];
        port_prio_r[i] <= pwdata[lac_pkg::PCFG_PRIO_LSB +: lac_pkg::PRIO_W];
        if (g == '0 || g == port_grp_r[i]) begin
          port_grp_r[i] <= g;
        end else if (!port_active_r[i] || g > lac_pkg::GROUP_W'(NG) ||
                     others_in(g, i) >= 5'(lac_pkg::MAX_MEMBERS)) begin
          refused <= 1'b1;
        end else begin
          port_grp_r[i] <= g;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // LACP timing and member state
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      port_lacp[p] = (port_grp_r[p] != '0) && grp_lacp_r[3'(port_grp_r[p] - 4'h1)];
      expire[p]    = tick && seen_r[p] && !lacpdu_rx[p] &&
                     silence_r[p] == silence_limit(short_mode_r[p]) - lac_pkg::SIL_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_r <= '0;
      for (int p = 0; p < NP; p++) begin
        silence_r[p] <= '0;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (!port_lacp[p] || !link_up[p] || lacpdu_rx[p]) begin
          silence_r[p] <= '0;
        end else if (tick && silence_r[p] != silence_limit(short_mode_r[p])) begin
          silence_r[p] <= silence_r[p] + lac_pkg::SIL_W'(1);
        end
        if (!port_lacp[p] || !link_up[p] || expire[p]) begin
          seen_r[p] <= 1'b0;
        end else if (lacpdu_rx[p]) begin
          seen_r[p] <= partner_match[p];
        end
      end
    end
  end

  // Transmit on every tick in short mode, once per thirty in long
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lacpdu_tx <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        lacpdu_tx[p] <= tick && port_lacp[p] && link_up[p] && port_active_r[p] &&
                        (short_mode_r[p] || phase == 5'h00);
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      agg_nxt[p]   = (port_grp_r[p] != '0) && link_up[p] && port_active_r[p] &&
                     (!port_lacp[p] || (seen_r[p] && partner_match[p]));
      indiv_nxt[p] = port_lacp[p] && link_up[p] && !agg_nxt[p];
      down_nxt[p]  = port_lacp[p] && !link_up[p];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_aggregated <= '0;
    end else begin
      port_aggregated <= agg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_event[lac_pkg::IRQ_REFUSED] = refused;
  assign irq_event[lac_pkg::IRQ_REMOVED] = |expire;
  assign irq_event[lac_pkg::IRQ_JOINED]  = |(agg_nxt & ~port_aggregated);

  // A new event beats a same-cycle write-one clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_en && paddr == lac_pkg::IRQ_STATUS_OFF) ?
                    pwdata[lac_pkg::IRQ_W-1:0] : '0)) | irq_event;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Frame distribution
  // ----------------------------------------------------------------
  lac_hash_if hif ();

  lac_hash u_hash (
    .hif (hif)
  );

  assign hif.sel     = grp_hash_r[3'(frame_group - 4'h1)];
  assign hif.src_mac = src_mac;
  assign hif.dst_mac = dst_mac;
  assign hif.hash_source_ip  = hash_source_ip;
  assign hif.hash_destination_ip  = hash_destination_ip;

  logic [3:0]                 d_cnt;
  logic [3:0]                 d_pick;
  logic [3:0]                 d_seen;
  logic [lac_pkg::PORT_W-1:0] d_port;
  logic [lac_pkg::PORT_W-1:0] d_lead;
  logic [lac_pkg::PRIO_W-1:0] d_best;

  // Members counted in port order, so a hash value always lands on one port
  always_comb begin
    d_cnt  = 4'h0;
    d_seen = 4'h0;
    d_port = '0;
    d_lead = '0;
    d_best = '1;
    for (int p = 0; p < NP; p++) begin
      if (agg_nxt[p] && port_grp_r[p] == frame_group) begin
        d_cnt = d_cnt + 4'h1;
      end
    end
    d_pick = (d_cnt == 4'h0) ? 4'h0 : 4'(hif.hash % {4'h0, d_cnt});
    for (int p = 0; p < NP; p++) begin
      if (agg_nxt[p] && port_grp_r[p] == frame_group) begin
        if (d_seen == d_pick) begin
          d_port = lac_pkg::PORT_W'(p);
        end
        if (port_prio_r[p] < d_best || d_seen == 4'h0) begin
          d_best = port_prio_r[p];
          d_lead = lac_pkg::PORT_W'(p);
        end
        d_seen = d_seen + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dist_valid     <= 1'b0;
      dist_none      <= 1'b0;
      dist_port      <= '0;
      dist_lead_port <= '0;
    end else begin
      dist_valid     <= frame_valid;
      dist_none      <= frame_valid && d_cnt == 4'h0;
      dist_port      <= d_port;
      dist_lead_port <= d_lead;
    end
  end

endmodule
`default_nettype wire

// ===== sim/lac_monitor.sv
// Port checker for the link aggregation controller
`timescale 1ns/1ns
`default_nettype none
module lac_monitor (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        frame_valid,
  input wire logic        dist_valid,
  input wire logic        dist_none,
  input wire logic [4:0]  dist_port,
  input wire logic [27:0] lacpdu_tx,
  input wire logic [27:0] link_up,
  input wire logic [27:0] port_aggregated
);
  logic [27:0] link_q_r;

  // Link as the registered outputs saw it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_q_r <= '0;
    end else begin
      link_q_r <= link_up;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("access phase without pready");
  chk_dist_answer: assert property (frame_valid |=> dist_valid)
    else $error("distribution answer missing");
  chk_dist_quiet: assert property (!frame_valid |=> !dist_valid)
    else $error("distribution answer without request");
  chk_none_port: assert property (dist_valid && dist_none |-> dist_port == 5'h00)
    else $error("empty group with nonzero port");
  chk_dist_member: assert property (dist_valid && !dist_none |-> port_aggregated[dist_port])
    else $error("frame sent to a port that is not aggregated");
  chk_tx_gap: assert property ((|lacpdu_tx) |=> (lacpdu_tx == 28'h0000000) [*8])
    else $error("protocol units too close together");
  chk_tx_link: assert property ((lacpdu_tx & ~link_q_r) == 28'h0000000)
    else $error("protocol unit sent on a port without link");
  chk_agg_link: assert property ((port_aggregated & ~link_q_r) == 28'h0000000)
    else $error("port aggregated without link");

  cov_dist_none: cover property (dist_valid && dist_none);
  cov_tx_sent: cover property (|lacpdu_tx);
  cov_member_lost: cover property ($fell(|port_aggregated));
endmodule

bind lac_top lac_monitor u_lac_monitor (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pready(pready), .frame_valid(frame_valid), .dist_valid(dist_valid), .dist_none(dist_none),
  .dist_port(dist_port), .lacpdu_tx(lacpdu_tx), .link_up(link_up), .port_aggregated(port_aggregated));
`default_nettype wire

// ===== sim/lac_peer.sv
// Peer switch model echoing each protocol unit after a short or long lag
`timescale 1ns/1ns
`default_nettype none
module lac_peer (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [27:0] lacpdu_tx,
  input  wire logic [27:0] mute,
  input  wire logic        slow,
  output logic [27:0]      lacpdu_rx
);
  logic [2:0][27:0] lag_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lag_r <= '0;
    end else begin
      lag_r <= {lag_r[1:0], lacpdu_tx};
    end
  end

  // Echo paces the peer at the device's own send rate; mute models a dead peer
  assign lacpdu_rx = (slow ? lag_r[2] : lag_r[0]) & ~mute;
endmodule
`default_nettype wire

// ===== sim/link_aggregation_control_tb_top.sv
// Testbench for the link aggregation controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module link_aggregation_control_tb_top;
  logic        sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        frame_valid = 1'b0, slow = 1'b1, perr, pready, pslverr, dist_valid, dist_none, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdat, prdata, hash_source_ip = 32'hC0A80001, hash_destination_ip = 32'h0A000002;
  logic [47:0] src_mac = 48'h0123456789AB, dst_mac = 48'h00163E5A7F10;
  logic [3:0]  frame_group = 4'h0;
  logic [4:0]  dist_port, dist_lead_port;
  logic [27:0] link_up = '0, partner_match = '0, mute = '0, lacpdu_rx, lacpdu_tx, port_aggregated;
  int          n_fail = 0, total_checks = 0;
  time         t0;

  always #50 sys_clk = ~sys_clk;

  // Short tick keeps the three-second silence inside a few hundred cycles
  lac_top #(.TICK_CYCLES(20)) u_lac_top (.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_up(link_up), .lacpdu_rx(lacpdu_rx), .partner_match(partner_match), .lacpdu_tx(lacpdu_tx),
    .port_aggregated(port_aggregated), .frame_valid(frame_valid), .frame_group(frame_group), .src_mac(src_mac),
    .dst_mac(dst_mac), .hash_source_ip(hash_source_ip), .hash_destination_ip(hash_destination_ip), .dist_valid(dist_valid), .dist_none(dist_none),
    .dist_port(dist_port), .dist_lead_port(dist_lead_port), .irq(irq));
  lac_peer u_lac_peer (.sys_clk(sys_clk), .reset_n(reset_n), .lacpdu_tx(lacpdu_tx), .mute(mute), .slow(slow),
    .lacpdu_rx(lacpdu_rx));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask

  // Byte fold of the selected address field, expected member index source
  function automatic logic [7:0] hf(input int m);
    logic [47:0] v;
    logic [7:0]  h;
    v = (m == 0) ? src_mac : (m == 1) ? dst_mac : (m == 2) ? src_mac ^ dst_mac :
        {16'h0, (m == 3) ? hash_source_ip : (m == 4) ? hash_destination_ip : hash_source_ip ^ hash_destination_ip};
    h = 8'h00;
    for (int i = 0; i < 6; i++) h ^= v[8*i +: 8];
    return h;
  endfunction

  // Two back-to-back requests with identical fields, each answer checked
  task automatic fr(input logic [3:0] g, input logic [4:0] ep, input logic en, input logic [4:0] el);
    @(posedge sys_clk);
    {frame_valid, frame_group} <= {1'b1, g};
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      if (k == 1) frame_valid <= 1'b0;
      @(negedge sys_clk);
      `CHK({dist_valid, dist_none, dist_port}, {1'b1, en, ep})
      if (!en) `CHK(dist_lead_port, el)
    end
  endtask

  initial begin
    repeat (3000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdc(lac_pkg::PORT_CFG_OFF, 32'h80000000);
    rdc(lac_pkg::GROUP_CFG_OFF + 12'h01C, 32'h00000004);
    xfer(1'b0, 12'hFFC, 32'h0);
    `CHK(perr, 1'b1)
    xfer(1'b1, lac_pkg::PORT_ACTIVE_OFF, 32'h0FFFFFDF);
    xfer(1'b1, lac_pkg::PORT_CFG_OFF + 12'h014, 32'h12340001);
    rdc(lac_pkg::PORT_CFG_OFF + 12'h014, 32'h12340000);
    rdc(lac_pkg::IRQ_STATUS_OFF, 32'h00000001);
    `CHK(irq, 1'b0)
    xfer(1'b1, lac_pkg::IRQ_MASK_OFF, 32'h00000007);
    rdc(lac_pkg::IRQ_STATUS_OFF, 32'h00000001);
    `CHK(irq, 1'b1)
    xfer(1'b1, lac_pkg::IRQ_STATUS_OFF, 32'h00000007);
    rdc(lac_pkg::IRQ_STATUS_OFF, 32'h00000000);
    `CHK(irq, 1'b0)
    link_up <= 28'h000030C;
    xfer(1'b1, lac_pkg::PORT_CFG_OFF + 12'h008, 32'h80000001);
    xfer(1'b1, lac_pkg::PORT_CFG_OFF + 12'h00C, 32'h00100001);
    for (int m = 0; m < 6; m++) begin
      xfer(1'b1, lac_pkg::GROUP_CFG_OFF, 32'(m << 1));
      fr(4'h1, 5'(2 + hf(m) % 2), 1'b0, 5'h03);
    end
    fr(4'h2, 5'h00, 1'b1, 5'h00);
    xfer(1'b1, lac_pkg::GROUP_CFG_OFF + 12'h008, 32'h00000005);
    xfer(1'b1, lac_pkg::SILENCE_OFF, 32'h00000300);
    for (int p = 0; p < 3; p++) xfer(1'b1, lac_pkg::PORT_CFG_OFF + 12'h020 + 12'(4 * p), 32'h80000003);
    partner_match <= 28'h0000100;
    repeat (80) @(posedge sys_clk);
    rdc(lac_pkg::AGG_STAT_OFF, 32'h0000010C);
    `CHK(port_aggregated, 28'h000010C)
    rdc(lac_pkg::INDIV_STAT_OFF, 32'h00000200);
    rdc(lac_pkg::DOWN_STAT_OFF, 32'h00000400);
    rdc(lac_pkg::IRQ_STATUS_OFF, 32'h00000004);
    fr(4'h3, 5'h08, 1'b0, 5'h08);
    @(posedge lacpdu_tx[8]);
    repeat (5) @(posedge sys_clk);
    mute <= 28'h0000100;
    repeat (30) @(posedge sys_clk);
    rdc(lac_pkg::AGG_STAT_OFF, 32'h0000010C);
    repeat (50) @(posedge sys_clk);
    rdc(lac_pkg::AGG_STAT_OFF, 32'h0000000C);
    rdc(lac_pkg::IRQ_STATUS_OFF, 32'h00000006);
    fr(4'h3, 5'h00, 1'b1, 5'h00);
    xfer(1'b1, lac_pkg::SILENCE_OFF, 32'h0);
    @(posedge sys_clk);
    @(posedge lacpdu_tx[9]) t0 = $time;
    @(posedge lacpdu_tx[9]) `CHK($time - t0, 64'(lac_pkg::LONG_INTERVAL_S * 2000))
    stop_test();
  end
endmodule
`default_nettype wire
